/* File: design/msc_pkg.sv */
// Shared constants and types for the mode and system control registers
package msc_pkg;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_MODE_PIN_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SYSTEM_CONTROL = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_PIN_FUNCTION = 8'h02;

  // Mode status field positions
  localparam int MPS_RSVD_HI = 7;
  localparam int MPS_ZERO_MSB = 6;
  localparam int MPS_ZERO_LSB = 3;
  localparam int MPS_PIN_MSB = 2;
  localparam int MPS_PIN_LSB = 0;

  // System control field positions
  localparam int SC_MAC_SAT = 7;
  localparam int SC_IRQ_MSB = 5;
  localparam int SC_IRQ_LSB = 4;
  localparam int SC_NMI_EDGE = 3;
  localparam int SC_RAM_EN = 0;

  // Pin function field position
  localparam int PF_F7_ALT = 0;

  // Reset values
  localparam logic MPS_RSVD_HI_RST = 1'b1;
  localparam logic [2:0] MPS_PIN_RST = 3'h0;
  localparam logic SC_MAC_SAT_RST = 1'b0;
  localparam logic SC_NMI_EDGE_RST = 1'b0;
  localparam logic SC_RAM_EN_RST = 1'b1;
  localparam logic PF_F7_ALT_RST = 1'b0;
  localparam logic NMI_PREV_RST = 1'b1;

  // Only single-chip advanced operation exists
  localparam logic [2:0] MODE7_PINS = 3'h7;
  localparam int ADDR_SPACE_BITS = 24;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 8'h00;

  // Interrupt controller modes; the odd codes are prohibited
  typedef enum logic [1:0] {
    MSC_IRQ_MODE0 = 2'b00,
    MSC_IRQ_BAD1 = 2'b01,
    MSC_IRQ_MODE2 = 2'b10,
    MSC_IRQ_BAD3 = 2'b11
  } msc_irq_mode_t;

  // One register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } msc_req_t;

  // Settings that steer the rest of the chip
  typedef struct packed {
    logic mac_saturate_select;
    msc_irq_mode_t irq_mode;
    logic nmi_edge_select;
    logic onchip_ram_enable;
    logic portf_bit7_alt;
  } msc_ctrl_t;

endpackage : msc_pkg

/* File: design/msc_regs.sv */
// Mode pin status and system control register bank
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
module msc_regs (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire msc_pkg::msc_req_t req,
  output logic [msc_pkg::DATA_W-1:0] rdata,
  input wire logic [2:0] mode_pin,
  input wire logic nmi_pin,
  output logic nmi_request,
  output msc_pkg::msc_ctrl_t ctrl,
  output logic mode7_ok,
  output logic onchip_rom_enable,
  output logic ext_bus_enable,
  output logic [msc_pkg::ADDR_W-1:0] addr_space_bits
);
  import msc_pkg::*;

  // Address match, used for every register
  function automatic logic msc_hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    msc_hit = (a == ofs);
  endfunction : msc_hit

  // Legal interrupt mode codes
  function automatic logic msc_irq_legal(input logic [1:0] code);
    msc_irq_legal = (code == MSC_IRQ_MODE0) || (code == MSC_IRQ_MODE2);
  endfunction : msc_irq_legal

  // Stored state
  logic mps_rsvd_hi_r;
  logic mps_rsvd_hi_nxt;
  logic [2:0] mode_status_r;
  logic [2:0] mode_status_nxt;
  logic mac_sat_r;
  logic mac_sat_nxt;
  msc_irq_mode_t irq_mode_r;
  msc_irq_mode_t irq_mode_nxt;
  logic nmi_edge_r;
  logic nmi_edge_nxt;
  logic ram_en_r;
  logic ram_en_nxt;
  logic f7_alt_r;
  logic f7_alt_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic nmi_prev_r;
  logic nmi_req_r;
  logic nmi_req_nxt;
  logic mode7_r;

  // Strobe decode
  wire hit_mps = msc_hit(req.addr, OFS_MODE_PIN_STATUS);
  wire hit_sc = msc_hit(req.addr, OFS_SYSTEM_CONTROL);
  wire hit_pf = msc_hit(req.addr, OFS_PIN_FUNCTION);
  wire wr_mps = req.wr && hit_mps;
  wire wr_sc = req.wr && hit_sc;
  wire wr_pf = req.wr && hit_pf;
  wire rd_mps = req.rd && hit_mps;
  wire [1:0] irq_wr_code = req.wdata[SC_IRQ_MSB:SC_IRQ_LSB];

  assign mps_rsvd_hi_nxt = wr_mps ? req.wdata[MPS_RSVD_HI] : mps_rsvd_hi_r;

  // pin levels caught only on status read
  assign mode_status_nxt = rd_mps ? mode_pin : mode_status_r;

  assign mac_sat_nxt = wr_sc ? req.wdata[SC_MAC_SAT] : mac_sat_r;

  // prohibited codes keep the old mode
  assign irq_mode_nxt = (wr_sc && msc_irq_legal(irq_wr_code))
                        ? msc_irq_mode_t'(irq_wr_code) : irq_mode_r;

  assign nmi_edge_nxt = wr_sc ? req.wdata[SC_NMI_EDGE] : nmi_edge_r;

  assign ram_en_nxt = wr_sc ? req.wdata[SC_RAM_EN] : ram_en_r;

  // port F bit 7 alternate use, I/O by default
  assign f7_alt_nxt = wr_pf ? req.wdata[PF_F7_ALT] : f7_alt_r;

  // Status image; read shows the freshly caught pins
  wire [DATA_W-1:0] mps_image;
  assign mps_image[MPS_ZERO_MSB:MPS_ZERO_LSB] = 4'h0;
  assign mps_image[MPS_RSVD_HI] = mps_rsvd_hi_r;
  // low bits carry pin levels in order
  assign mps_image[MPS_PIN_MSB:MPS_PIN_LSB] = mode_pin;

  // Control image
  wire [DATA_W-1:0] sc_image;
  assign sc_image = {mac_sat_r, 1'b0, irq_mode_r, nmi_edge_r, 2'b00, ram_en_r};

  // Pin function image
  wire [DATA_W-1:0] pf_image = {7'h00, f7_alt_r};

  // Read mux; unmapped addresses answer zero
  assign rdata_nxt = !req.rd ? rdata_r :
                     hit_mps ? mps_image :
                     hit_sc ? sc_image :
                     hit_pf ? pf_image : UNMAPPED_RDATA;

  // NMI edge detect against the selected polarity
  wire nmi_rise = nmi_pin && !nmi_prev_r;
  wire nmi_fall = !nmi_pin && nmi_prev_r;
  assign nmi_req_nxt = nmi_edge_r ? nmi_rise : nmi_fall;

  // Status register state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mps_rsvd_hi_r <= MPS_RSVD_HI_RST;
      mode_status_r <= MPS_PIN_RST;
    end else if (clk_en) begin
      mps_rsvd_hi_r <= mps_rsvd_hi_nxt;
      mode_status_r <= mode_status_nxt;
    end
  end

  // Control register state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mac_sat_r <= SC_MAC_SAT_RST;
      // mode 0 in force after reset
      irq_mode_r <= MSC_IRQ_MODE0;
      nmi_edge_r <= SC_NMI_EDGE_RST;
      ram_en_r <= SC_RAM_EN_RST;
      f7_alt_r <= PF_F7_ALT_RST;
    end else if (clk_en) begin
      mac_sat_r <= mac_sat_nxt;
      irq_mode_r <= irq_mode_nxt;
      nmi_edge_r <= nmi_edge_nxt;
      ram_en_r <= ram_en_nxt;
      f7_alt_r <= f7_alt_nxt;
    end
  end

  // Read data register; holds between reads
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= UNMAPPED_RDATA;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  // NMI sampling; idle-high pin so no false fall
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_prev_r <= NMI_PREV_RST;
      nmi_req_r <= 1'b0;
    end else if (clk_en) begin
      nmi_prev_r <= nmi_pin;
      nmi_req_r <= nmi_req_nxt;
    end
  end

  // Mode pin check, a board fault if ever low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode7_r <= 1'b0;
    end else if (clk_en) begin
      mode7_r <= (mode_pin == MODE7_PINS);
    end
  end

  // Outputs
  assign rdata = rdata_r;
  assign nmi_request = nmi_req_r;
  assign mode7_ok = mode7_r;
  assign ctrl.mac_saturate_select = mac_sat_r;
  assign ctrl.irq_mode = irq_mode_r;
  assign ctrl.nmi_edge_select = nmi_edge_r;
  assign ctrl.onchip_ram_enable = ram_en_r;
  // pin is plain I/O unless switched
  assign ctrl.portf_bit7_alt = f7_alt_r;
  // single chip: ROM on, no external bus
  assign onchip_rom_enable = 1'b1;
  assign ext_bus_enable = 1'b0;
  assign addr_space_bits = ADDR_W'(ADDR_SPACE_BITS);

endmodule : msc_regs

/* File: tb/msc_regs_properties.sv */
// Checker for the mode and system control bank
`timescale 1ns/1ps
module msc_regs_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire msc_pkg::msc_req_t req,
  input wire logic [msc_pkg::DATA_W-1:0] rdata,
  input wire logic [2:0] mode_pin,
  input wire logic nmi_pin,
  input wire logic nmi_request,
  input wire msc_pkg::msc_ctrl_t ctrl,
  input wire logic mode7_ok,
  input wire logic onchip_rom_enable,
  input wire logic ext_bus_enable,
  input wire logic [msc_pkg::ADDR_W-1:0] addr_space_bits
);
  import msc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Accesses actually taken by the bank
  wire rd_st = clk_en && req.rd && req.addr == OFS_MODE_PIN_STATUS;
  wire rd_sc = clk_en && req.rd && req.addr == OFS_SYSTEM_CONTROL;
  wire wr_sc = clk_en && req.wr && req.addr == OFS_SYSTEM_CONTROL;
  a_status_pins: assert property (rd_st |=> rdata[2:0] == $past(mode_pin))
    else $error("pins");
  a_status_zeros: assert property (rd_st |=> rdata[6:3] == 4'h0) else $error("zeros");
  a_ctrl_rsvd: assert property (rd_sc |=> {rdata[6], rdata[2:1]} == 3'h0)
    else $error("rsvd");
  a_ctrl_write: assert property (wr_sc |=> {ctrl.mac_saturate_select, ctrl.nmi_edge_select,
    ctrl.onchip_ram_enable} == $past({req.wdata[7], req.wdata[3], req.wdata[0]}))
    else $error("write");
  a_irq_refused: assert property (wr_sc && req.wdata[4] |=> $stable(ctrl.irq_mode))
    else $error("irq bad");
  a_irq_taken: assert property (wr_sc && !req.wdata[4] |=>
    ctrl.irq_mode == $past(req.wdata[5:4]))
    else $error("irq");
  a_fixed_space: assert property (onchip_rom_enable && !ext_bus_enable
    && addr_space_bits == 8'h18) else $error("space");
  a_nmi_edge: assert property (clk_en && $past(clk_en) && $past(rst_b) &&
    (ctrl.nmi_edge_select ? $rose(nmi_pin) : $fell(nmi_pin)) |=> nmi_request) else $error("nmi");
  // Main scenarios reached
  cover property (rd_st);
  cover property (wr_sc && req.wdata[4]);
  cover property (nmi_request);
endmodule : msc_regs_properties
bind msc_regs msc_regs_properties msc_regs_properties_inst (.ref_clk(ref_clk), .rst_b(rst_b),
  .clk_en(clk_en), .req(req), .rdata(rdata), .mode_pin(mode_pin), .nmi_pin(nmi_pin),
  .nmi_request(nmi_request), .ctrl(ctrl), .mode7_ok(mode7_ok),
  .onchip_rom_enable(onchip_rom_enable), .ext_bus_enable(ext_bus_enable),
  .addr_space_bits(addr_space_bits));

/* File: tb/test_msc_regs.sv */
// Self-checking bench for the mode and system control bank
`timescale 1ns/1ps
module test_msc_regs;
  import msc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  msc_req_t req = '0;
  logic [2:0] mode_pin = 3'h7;
  logic nmi_pin = 1'b1;
  logic [7:0] rdata, space;
  logic nmi_request, rom_en, ext_en, mode7;
  msc_ctrl_t ctrl;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // Control writes and their readback; odd irq codes keep the old mode
  logic [7:0] sc_wr [4] = '{8'hA9, 8'h56, 8'hFF, 8'h08};
  logic [7:0] sc_rd [4] = '{8'hA9, 8'h20, 8'hA9, 8'h08};
  msc_regs msc_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req),
    .rdata(rdata), .mode_pin(mode_pin), .nmi_pin(nmi_pin), .nmi_request(nmi_request),
    .ctrl(ctrl), .mode7_ok(mode7), .onchip_rom_enable(rom_en), .ext_bus_enable(ext_en),
    .addr_space_bits(space));
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // One-cycle strobe; read data is looked at in the following cycle
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk);
    req <= '{a, d, w, !w};
    @(posedge ref_clk);
    req <= '0;
    #1;
  endtask : bus
  task automatic nmi_step(input logic v, input logic e);
    @(posedge ref_clk);
    nmi_pin <= v;
    @(posedge ref_clk);
    #1;
    chk({7'h0, nmi_request}, {7'h0, e});
  endtask : nmi_step
  task automatic do_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({2'h0, ctrl}, 8'h02);
    chk({6'h0, rom_en, ext_en}, 8'h02);
    chk(space, 8'h18);
    chk({7'h0, mode7}, 8'h01);
  endtask : do_reset
  // Hang guard; the tests need under a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) mode_pin <= 3'(1 << i);
      bus(OFS_MODE_PIN_STATUS, 8'hF8, 1'b1);
      bus(OFS_MODE_PIN_STATUS, 8'h00, 1'b0);
      chk(rdata, {5'h10, 3'(1 << i)});
    end
    // Board pins back to all high for the rest of the run
    @(posedge ref_clk) mode_pin <= 3'h7;
    for (int i = 0; i < 4; i++) begin
      bus(OFS_SYSTEM_CONTROL, sc_wr[i], 1'b1);
      chk({2'h0, ctrl}, {2'h0, sc_rd[i][7], sc_rd[i][5:3], sc_rd[i][0], 1'b0});
      bus(OFS_SYSTEM_CONTROL, 8'h00, 1'b0);
      chk(rdata, sc_rd[i]);
    end
    bus(8'h7F, 8'h00, 1'b0);
    chk(rdata, UNMAPPED_RDATA);
    bus(OFS_PIN_FUNCTION, 8'h01, 1'b1);
    chk({7'h0, ctrl.portf_bit7_alt}, 8'h01);
    nmi_step(1'b0, 1'b0);
    nmi_step(1'b1, 1'b1);
    nmi_step(1'b1, 1'b0);
    bus(OFS_SYSTEM_CONTROL, 8'h01, 1'b1);
    nmi_step(1'b0, 1'b1);
    nmi_step(1'b0, 1'b0);
    // Frozen bank ignores a write
    @(posedge ref_clk) clk_en <= 1'b0;
    bus(OFS_SYSTEM_CONTROL, 8'hA8, 1'b1);
    chk({2'h0, ctrl}, 8'h03);
    @(posedge ref_clk) clk_en <= 1'b1;
    bus(OFS_SYSTEM_CONTROL, 8'h00, 1'b1);
    chk({7'h0, ctrl.onchip_ram_enable}, 8'h00);
    do_reset();
    give_verdict();
  end
endmodule : test_msc_regs
